// ===== include/asr_pkg.sv
// package: pin timing constants and carrier types for the static memory controller
`default_nettype none
package asr_pkg;
    localparam int unsigned CLK_HZ            = 25_000_000;
    localparam int unsigned SUPPLY_SETTLE_US  = 100;
    localparam int unsigned SUPPLY_SETTLE_CYC =
        (SUPPLY_SETTLE_US * (CLK_HZ / 1_000_000));
    localparam int unsigned ADDR_W            = 16;
    localparam int unsigned DATA_W            = 16;
    localparam int unsigned LANE_W            = 8;
    localparam logic [1:0]  LANES_NONE        = 2'h0;

    typedef struct packed {
        logic              write;
        logic [1:0]        lanes;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asr_req_t;

    typedef struct packed {
        logic              chip_sel_n;
        logic              write_n;
        logic              out_drive_n;
        logic              low_lane_enable_n;
        logic              high_lane_enable_n;
        logic [ADDR_W-1:0] addr;
    } asr_pins_t;
endpackage
`default_nettype wire

// ===== rtl/asr_settle_timer.sv
// power-up wait counter: raises done after a fixed number of clocks
`timescale 1ns/1ps
`default_nettype none
module asr_settle_timer #(
    parameter int unsigned CYCLES = 2500
) (
    input  wire logic clk,
    input  wire logic nrst,
    output logic      done
);
    localparam int unsigned CW = (CYCLES < 2) ? 1 : $clog2(CYCLES + 1);
    if (CYCLES < 1) begin : g_bad_cycles
        $error("asr_settle_timer: CYCLES must be at least 1");
    end

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          done_r;
    logic          done_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        done_nxt = done_r;
        if (!done_r) begin
            if (cnt_r == CW'(CYCLES - 1)) begin
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + CW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule // asr_settle_timer
`default_nettype wire

// ===== rtl/asr_ctrl.sv
// host controller for a 64K x 16 asynchronous static memory
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl #(
    parameter int unsigned SETTLE_CYCLES = asr_pkg::SUPPLY_SETTLE_CYC,
    parameter int unsigned ACCESS_CYCLES = 1
) (
    input  wire logic                          clk,
    input  wire logic                          nrst,
    input  wire logic                          req_valid,
    input  wire asr_pkg::asr_req_t             req,
    output logic                               req_ready,
    output logic                               rsp_valid,
    output logic [asr_pkg::DATA_W-1:0]         rsp_rdata,
    output asr_pkg::asr_pins_t                 pins,
    input  wire logic [asr_pkg::DATA_W-1:0]    data_in,
    output logic [asr_pkg::DATA_W-1:0]         data_out,
    output logic [1:0]                         data_oe
);
    if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 255) begin : g_bad_access
        $error("asr_ctrl: ACCESS_CYCLES must be 1..255");
    end

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_WAIT  = 6'h01,
        ST_IDLE  = 6'h02,
        ST_WSET  = 6'h04,
        ST_WEND  = 6'h08,
        ST_RACC  = 6'h10,
        ST_RDONE = 6'h20
    } asr_state_t;

    function automatic logic [asr_pkg::DATA_W-1:0] lane_merge(
        input logic [1:0]                 lanes,
        input logic [asr_pkg::DATA_W-1:0] d
    );
        logic [asr_pkg::DATA_W-1:0] m;
        m = '0;
        if (lanes[0]) m[asr_pkg::LANE_W-1:0] = d[asr_pkg::LANE_W-1:0];
        if (lanes[1]) m[asr_pkg::DATA_W-1:asr_pkg::LANE_W] = d[asr_pkg::DATA_W-1:asr_pkg::LANE_W];
        return m;
    endfunction

    logic settle_done;

    asr_settle_timer #(
        .CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .clk  (clk),
        .nrst (nrst),
        .done (settle_done)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    asr_state_t                 st_r,    st_nxt;
    asr_pkg::asr_pins_t         pins_r,  pins_nxt;
    logic [asr_pkg::DATA_W-1:0] dout_r,  dout_nxt;
    logic [1:0]                 oe_r,    oe_nxt;
    logic [asr_pkg::DATA_W-1:0] rdat_r,  rdat_nxt;
    logic                       rv_r,    rv_nxt;
    logic [1:0]                 lanes_r, lanes_nxt;
    logic [7:0]                 cnt_r,   cnt_nxt;

    localparam asr_pkg::asr_pins_t PINS_IDLE = '{
        chip_sel_n: 1'b1, write_n: 1'b1, out_drive_n: 1'b1,
        low_lane_enable_n: 1'b1, high_lane_enable_n: 1'b1, addr: '0};

    assign req_ready = (st_r == ST_IDLE) && settle_done;

    always_comb begin
        st_nxt    = st_r;
        pins_nxt  = pins_r;
        dout_nxt  = dout_r;
        oe_nxt    = oe_r;
        rdat_nxt  = rdat_r;
        rv_nxt    = 1'b0;
        lanes_nxt = lanes_r;
        cnt_nxt   = cnt_r;
        case (st_r)
            ST_WAIT: begin
                if (settle_done) begin
                    st_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (req_valid && req_ready && req.lanes != asr_pkg::LANES_NONE) begin
                    // address and lanes set up together with select low
                    pins_nxt.addr               = req.addr;
                    pins_nxt.chip_sel_n         = 1'b0;
                    pins_nxt.low_lane_enable_n  = ~req.lanes[0];
                    pins_nxt.high_lane_enable_n = ~req.lanes[1];
                    lanes_nxt                   = req.lanes;
                    cnt_nxt                     = 8'(ACCESS_CYCLES);
                    if (req.write) begin
                        pins_nxt.out_drive_n = 1'b1;
                        pins_nxt.write_n     = 1'b0;
                        pins_nxt.write_n     = 1'b0;
                        dout_nxt             = req.wdata;
                        oe_nxt               = req.lanes;
                        st_nxt               = ST_WSET;
                    end else begin
                        pins_nxt.write_n     = 1'b1;
                        pins_nxt.out_drive_n = 1'b0;
                        oe_nxt               = 2'h0;
                        st_nxt               = ST_RACC;
                    end
                end else if (req_valid && req_ready) begin
                    rv_nxt = 1'b1;
                end
            end
            ST_WSET: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    // only write strobe rises; select stays low one more cycle
                    pins_nxt.write_n = 1'b1;
                    st_nxt           = ST_WEND;
                end
            end
            ST_WEND: begin
                // data still driven on the edge after the write ended
                pins_nxt = PINS_IDLE;
                oe_nxt   = 2'h0;
                rv_nxt   = 1'b1;
                st_nxt   = ST_IDLE;
            end
            ST_RACC: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    st_nxt = ST_RDONE;
                end
            end
            ST_RDONE: begin
                rdat_nxt = lane_merge(lanes_r, data_in);
                rv_nxt   = 1'b1;
                if (req_valid && settle_done && !req.write &&
                    req.lanes == lanes_r) begin
                    // address-driven follow-on read, strobes stay low
                    pins_nxt.addr = req.addr;
                    cnt_nxt       = 8'(ACCESS_CYCLES);
                    st_nxt        = ST_RACC;
                end else begin
                    pins_nxt = PINS_IDLE;
                    st_nxt   = ST_IDLE;
                end
            end
            default: begin
                pins_nxt = PINS_IDLE;
                oe_nxt   = 2'h0;
                st_nxt   = ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r    <= ST_WAIT;
            pins_r  <= PINS_IDLE;
            dout_r  <= '0;
            oe_r    <= 2'h0;
            rdat_r  <= '0;
            rv_r    <= 1'b0;
            lanes_r <= 2'h0;
            cnt_r   <= 8'h00;
        end else begin
            st_r    <= st_nxt;
            pins_r  <= pins_nxt;
            dout_r  <= dout_nxt;
            oe_r    <= oe_nxt;
            rdat_r  <= rdat_nxt;
            rv_r    <= rv_nxt;
            lanes_r <= lanes_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign pins      = pins_r;
    assign data_out  = dout_r;
    assign data_oe   = oe_r;
    assign rsp_valid = rv_r;
    assign rsp_rdata = rdat_r;
endmodule // asr_ctrl
`default_nettype wire

// ===== testbench/asr_sram_model.sv
// partner model: 64K x 16 asynchronous static memory with byte lanes
`timescale 1ns/1ps
`default_nettype none
module asr_sram_model (
    input  wire logic               clk,
    input  wire asr_pkg::asr_pins_t pins,
    input  wire logic [15:0]        data_out,
    input  wire logic [1:0]         data_oe,
    output logic [15:0]             data_in
);
    logic [15:0] mem [0:65535];
    logic [15:0] flt_r = 16'h5a5a;
    logic [1:0]  ln;
    logic [1:0]  rd;
    logic [1:0]  wr;
    initial foreach (mem[i]) mem[i] = 16'h0;
    assign ln = ~{pins.high_lane_enable_n, pins.low_lane_enable_n};
    assign rd = (!pins.chip_sel_n && !pins.out_drive_n && pins.write_n) ? ln : 2'h0;
    assign wr = (!pins.chip_sel_n && !pins.write_n) ? ln : 2'h0;
    // undriven lanes show a pattern that changes every cycle
    always @(posedge clk) flt_r <= ~flt_r;
    always @(negedge clk)
        for (int i = 0; i < 2; i++)
            if (wr[i]) mem[pins.addr][i*8 +: 8] <= data_in[i*8 +: 8];
    always_comb
        for (int i = 0; i < 2; i++)
            data_in[i*8 +: 8] = data_oe[i] ? data_out[i*8 +: 8] :
                rd[i] ? mem[pins.addr][i*8 +: 8] : flt_r[i*8 +: 8];
endmodule // asr_sram_model
`default_nettype wire

// ===== testbench/asr_ctrl_checker.sv
// checker: pin protocol assertions for the static memory controller
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl_checker #(
    parameter int unsigned SETTLE_CYCLES = asr_pkg::SUPPLY_SETTLE_CYC
) (
    input wire logic               clk,
    input wire logic               nrst,
    input wire logic               req_valid,
    input wire asr_pkg::asr_req_t  req,
    input wire logic               req_ready,
    input wire logic               rsp_valid,
    input wire logic [15:0]        rsp_rdata,
    input wire asr_pkg::asr_pins_t pins,
    input wire logic [15:0]        data_in,
    input wire logic [15:0]        data_out,
    input wire logic [1:0]         data_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [15:0] up_r;
    logic [15:0] up_nxt;
    logic        take;
    logic [1:0]  ln;
    logic [15:0] rd_w;
    assign take = req_valid && req_ready && req.lanes != 2'h0;
    assign ln = ~{pins.high_lane_enable_n, pins.low_lane_enable_n};
    assign rd_w = data_in & {{8{ln[1]}}, {8{ln[0]}}};
    always_comb up_nxt = (up_r == 16'hffff) ? up_r : up_r + 16'h1;
    always_ff @(posedge clk or negedge nrst)
        if (!nrst) up_r <= 16'h0;
        else up_r <= up_nxt;
    a_ready_after_wait: assert property (req_ready |-> up_r >= SETTLE_CYCLES)
        else $error("request accepted before power-up wait");
    a_no_early_sel: assert property (!pins.chip_sel_n |-> up_r > SETTLE_CYCLES)
        else $error("select asserted before power-up wait");
    a_read_we_high: assert property (!pins.chip_sel_n && !pins.out_drive_n |-> pins.write_n)
        else $error("write strobe low during read");
    a_oe_no_drive: assert property (!pins.out_drive_n |-> data_oe == 2'h0)
        else $error("host drives bus while output drive low");
    a_addr_at_sel: assert property ($fell(pins.chip_sel_n) |-> pins.addr == $past(req.addr))
        else $error("address not valid at select");
    a_write_start: assert property (take && req.write |=>
        !pins.chip_sel_n && !pins.write_n && ln == $past(req.lanes) && data_oe == ln)
        else $error("write strobes or lanes wrong");
    a_read_start: assert property (take && !req.write |=>
        !pins.chip_sel_n && !pins.out_drive_n && ln == $past(req.lanes) && data_oe == 2'h0)
        else $error("read strobes or lanes wrong");
    a_write_end_seq: assert property (take && req.write |-> ##2
        pins.write_n && !pins.chip_sel_n && $stable(data_out) && data_oe != 2'h0
        ##1 pins.chip_sel_n)
        else $error("write end order or data hold wrong");
    a_read_data: assert property (rsp_valid && !$past(pins.out_drive_n) &&
        !$past(pins.chip_sel_n) |-> rsp_rdata == $past(rd_w))
        else $error("read data not taken from enabled lanes");
    c_write: cover property (take && req.write);
    c_follow: cover property (rsp_valid && !pins.chip_sel_n);
    c_empty: cover property (req_valid && req_ready && req.lanes == 2'h0);
endmodule // asr_ctrl_checker
bind asr_ctrl asr_ctrl_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (
    .clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

// ===== testbench/async_sram_byte_lane_access_tb_top.sv
// testbench: random and corner accesses through the static memory controller
`timescale 1ns/1ps
`default_nettype none
module async_sram_byte_lane_access_tb_top;
    localparam int unsigned SETTLE = 4;
    logic               clk = 1'b0;
    logic               nrst = 1'b0;
    logic               req_valid = 1'b0;
    asr_pkg::asr_req_t  req = '0;
    logic               req_ready;
    logic               rsp_valid;
    logic [15:0]        rsp_rdata;
    asr_pkg::asr_pins_t pins;
    logic [15:0]        data_in;
    logic [15:0]        data_out;
    logic [1:0]         data_oe;
    logic [15:0]        mem_x [0:65535];
    logic [31:0]        r;
    logic [31:0]        r2;
    int                 miscompares = 0;
    int                 n_checks = 0;
    int                 seed = 32'h4960;
    always #20 clk = ~clk;
    asr_ctrl #(.SETTLE_CYCLES(SETTLE)) i_dut (.clk(clk), .nrst(nrst), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .pins(pins), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
    asr_sram_model i_mem (.clk(clk), .pins(pins), .data_out(data_out), .data_oe(data_oe),
        .data_in(data_in));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic logic [15:0] msk(input logic [1:0] ln);
        return {{8{ln[1]}}, {8{ln[0]}}};
    endfunction
    task automatic do_reset;
        int n;
        n = 0;
        nrst = 1'b0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        while (!req_ready && n < 100) begin @(negedge clk); n++; end
        check(16'(req_ready), 16'h1);
        check(16'(n >= SETTLE), 16'h1);
    endtask
    task automatic access(input logic w, input logic [1:0] ln, input logic [15:0] a,
                          input logic [15:0] d, input bit fol, input logic [15:0] a2);
        logic [15:0] q [$];
        int n;
        int p;
        n = 0;
        p = 0;
        while (!req_ready && n < 100) begin @(negedge clk); n++; end
        check(16'(req_ready), 16'h1);
        req_valid = 1'b1;
        req = '{w, ln, a, d};
        if (!w && ln != 2'h0) q.push_back(mem_x[a] & msk(ln));
        if (w) mem_x[a] = (mem_x[a] & ~msk(ln)) | (d & msk(ln));
        // responses are sampled from the first falling edge after the take
        for (int k = 0; k < 12; k++) begin
            @(negedge clk);
            if (k == 0 || k == 2) req_valid = 1'b0;
            if (k == 1 && fol) begin
                req_valid = 1'b1;
                req.addr = a2;
                if (ln != 2'h0) q.push_back(mem_x[a2] & msk(ln));
            end
            if (rsp_valid) begin
                p++;
                if (q.size() > 0) check(rsp_rdata, q.pop_front());
            end
        end
        check(16'(p), fol ? 16'h2 : 16'h1);
    endtask
    initial begin
        foreach (mem_x[i]) mem_x[i] = 16'h0;
        do_reset();
        for (int l = 0; l < 4; l++) access(1'b1, 2'(l), 16'hffff, 16'h1234 * 16'(l + 1), 0, 0);
        for (int l = 0; l < 4; l++) access(1'b0, 2'(l), 16'hffff, 16'h0, 0, 0);
        $display("done: lane codes");
        access(1'b1, 2'h3, 16'h0, 16'ha55a, 0, 0);
        access(1'b0, 2'h3, 16'h0, 16'h0, 1, 16'hffff);
        access(1'b0, 2'h1, 16'hffff, 16'h0, 1, 16'h0);
        $display("done: follow-on reads");
        repeat (60) begin
            r = $random(seed);
            r2 = $random(seed);
            access(r[20], r[17:16], r[15:0] & 16'h000f, r2[15:0], r[21] & ~r[20], r2[31:16] & 16'h000f);
        end
        $display("done: random");
        do_reset();
        access(1'b0, 2'h3, 16'h0, 16'h0, 0, 0);
        $display("done: mid-run reset");
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
endmodule // async_sram_byte_lane_access_tb_top
`default_nettype wire
